// file: design/dct_map.vh
// Register offsets, field positions, reset values and divider counts of the dual timer
`ifndef DCT_MAP_VH
`define DCT_MAP_VH

// ***************************************************************
// Register offsets (byte index on the register port)
// ***************************************************************
`define DCT_ADDR_W          4
`define DCT_A_CONTROL       4'h0
`define DCT_A_MODE          4'h1
`define DCT_A_FIRST_LOW     4'h2
`define DCT_A_SECOND_LOW    4'h3
`define DCT_A_FIRST_HIGH    4'h4
`define DCT_A_SECOND_HIGH   4'h5
`define DCT_A_CLOCK_CTL     4'h6
`define DCT_A_IRQ_ENABLE    4'h7
`define DCT_A_EXT_CONFIG    4'h8

// ***************************************************************
// Control register fields
// ***************************************************************
`define DCT_CT_SECOND_OVF   7
`define DCT_CT_SECOND_RUN   6
`define DCT_CT_FIRST_OVF    5
`define DCT_CT_FIRST_RUN    4

// ***************************************************************
// Mode register fields
// ***************************************************************
`define DCT_MD_FIRST_MODE   1:0
`define DCT_MD_FIRST_CSEL   2
`define DCT_MD_FIRST_GATE   3
`define DCT_MD_SECOND_MODE  5:4
`define DCT_MD_SECOND_CSEL  6
`define DCT_MD_SECOND_GATE  7

// ***************************************************************
// Clock control, interrupt enable and external input fields
// ***************************************************************
`define DCT_CK_SECOND_SYS   3
`define DCT_CK_FIRST_SYS    2
`define DCT_CK_SCALE        1:0
`define DCT_IE_FIRST        0
`define DCT_IE_SECOND       1
`define DCT_EC_FIRST_POL    0
`define DCT_EC_SECOND_POL   1

// ***************************************************************
// Mode codes
// ***************************************************************
`define DCT_MODE_13BIT      2'h0
`define DCT_MODE_16BIT      2'h1
`define DCT_MODE_RELOAD     2'h2
`define DCT_MODE_SPLIT      2'h3

// ***************************************************************
// Prescaler: scale codes and terminal counts (divide minus one)
// ***************************************************************
`define DCT_SC_DIV12        2'h0
`define DCT_SC_DIV4         2'h1
`define DCT_SC_DIV48        2'h2
`define DCT_SC_EXT8         2'h3
`define DCT_PS_W            6
`define DCT_PS_TERM12       6'h0B
`define DCT_PS_TERM4        6'h03
`define DCT_PS_TERM48       6'h2F
`define DCT_PS_TERM8        6'h07

// ***************************************************************
// Reset values
// ***************************************************************
`define DCT_RST_BYTE        8'h00
`define DCT_RST_PS          6'h00

`endif

// file: design/dct_pin_sync.v
// Two-flop synchroniser for one pin with edge detection on synchronised samples
`timescale 1ns/10ps
`default_nettype none

module dct_pin_sync (
  // Clock and reset
  input  wire ref_clk,
  input  wire arst_n,
  // Asynchronous pin
  input  wire pinIn,
  // Synchronised level and edges
  output wire pinLevel,
  output wire pinFall,
  output wire pinRise
);

  reg stage1_r;
  reg stage2_r;
  reg prev_r;

  // First stage feeds only the second stage to keep metastability contained
  always @(posedge ref_clk or negedge arst_n) begin
    if (!arst_n) begin
      stage1_r <= 1'b0;
      stage2_r <= 1'b0;
      prev_r   <= 1'b0;
    end else begin
      stage1_r <= pinIn;
      stage2_r <= stage1_r;
      prev_r   <= stage2_r;
    end
  end

  assign pinLevel = stage2_r;
  assign pinFall  = prev_r & ~stage2_r;
  assign pinRise  = ~prev_r & stage2_r;

endmodule // dct_pin_sync

`default_nettype wire

// file: design/dct_timer_top.v
// Dual counter/timer with four modes, shared prescaler and byte-wide register port
//
// Notes on behaviour
// - Each timer keeps a 16-bit count read and written as low and high bytes.
// - Each timer has its own two mode bits, set independently.
// - Mode 0 counts 13 bits: high byte plus low-byte bits 4 to 0.
// - Mode 0 wrap from all ones sets the overflow flag; enabled flag requests interrupt.
// - Counter-select high: each falling edge on the count pin increments.
// - Counter-select low: system clock if clock-select high, else prescaler output.
// - Count only when run is set and gate is clear or gate input active.
// - Second timer gates on second external input with its own polarity bit.
// - Setting run leaves the count as it stands.
// - Mode 1 is mode 0 over all 16 bits.
// - Mode 2 low byte counts, reloads from high byte on wrap, sets flag.
// - Mode 3 first low byte uses first run, select, gate and flag.
// - Mode 3 first high byte times internal clock, run by second run, sets second flag.
// - First in mode 3: second timer counts but no external clock, flag or interrupt.
// - Second timer overflow tick stays available, also while first is in mode 3.
// - First in mode 3: second runs in modes 0 to 2, stops in mode 3.
// - Overflow requests an interrupt only when its enable bit is set.
// - Prescaler gives system clock /12, /4, /48, or external clock /8 synchronised.
// - Overflow flags clear by software write or on vector acknowledge.
`timescale 1ns/10ps
`default_nettype none
`include "dct_map.vh"

module dct_timer_top (
  // Clock and reset
  input  wire                    ref_clk,
  input  wire                    arst_n,
  // Register port
  input  wire [`DCT_ADDR_W-1:0]  regAddr,
  input  wire [7:0]              regWrData,
  input  wire                    regWrStb,
  input  wire                    regRdStb,
  output wire [7:0]              regRdData,
  // External pins
  input  wire                    firstCountPin,
  input  wire                    secondCountPin,
  input  wire                    firstExtIrqInput,
  input  wire                    secondExtIrqInput,
  input  wire                    extClockPin,
  // Interrupt vector acknowledge from the interrupt controller
  input  wire                    firstIrqAck,
  input  wire                    secondIrqAck,
  // Interrupt requests and overflow tick
  output wire                    firstIrqReq,
  output wire                    secondIrqReq,
  output wire                    secondOverflowTick
);

  // ***************************************************************
  // Register state
  // ***************************************************************
  reg [7:0]            firstCountLow_r;
  reg [7:0]            firstCountHigh_r;
  reg [7:0]            secondCountLow_r;
  reg [7:0]            secondCountHigh_r;
  reg [7:0]            timerModeReg_r;
  reg [7:0]            clockControlReg_r;
  reg [7:0]            irqEnableReg_r;
  reg [7:0]            extIrqConfigReg_r;
  reg                  firstRunBit_r;
  reg                  secondRunBit_r;
  reg                  firstOverflowFlag_r;
  reg                  secondOverflowFlag_r;
  reg [7:0]            rdData_r;
  reg                  ovfTick_r;
  reg [`DCT_PS_W-1:0]  presc_r;

  // ***************************************************************
  // Pin synchronisers
  // ***************************************************************
  wire firstCntFall;
  wire secondCntFall;
  wire firstGateLvl;
  wire secondGateLvl;
  wire extClkRise;

  dct_pin_sync uSyncFirstCnt (
    .ref_clk  (ref_clk),
    .arst_n   (arst_n),
    .pinIn    (firstCountPin),
    .pinLevel (),
    .pinFall  (firstCntFall),
    .pinRise  ()
  );

  dct_pin_sync uSyncSecondCnt (
    .ref_clk  (ref_clk),
    .arst_n   (arst_n),
    .pinIn    (secondCountPin),
    .pinLevel (),
    .pinFall  (secondCntFall),
    .pinRise  ()
  );

  dct_pin_sync uSyncFirstGate (
    .ref_clk  (ref_clk),
    .arst_n   (arst_n),
    .pinIn    (firstExtIrqInput),
    .pinLevel (firstGateLvl),
    .pinFall  (),
    .pinRise  ()
  );

  dct_pin_sync uSyncSecondGate (
    .ref_clk  (ref_clk),
    .arst_n   (arst_n),
    .pinIn    (secondExtIrqInput),
    .pinLevel (secondGateLvl),
    .pinFall  (),
    .pinRise  ()
  );

  dct_pin_sync uSyncExtClk (
    .ref_clk  (ref_clk),
    .arst_n   (arst_n),
    .pinIn    (extClockPin),
    .pinLevel (),
    .pinFall  (),
    .pinRise  (extClkRise)
  );

  // ***************************************************************
  // Shared prescaler
  // ***************************************************************
  reg [`DCT_PS_W-1:0] prescTerm;
  reg                 prescAdvance;
  wire                prescTick;

  always @* begin
    prescAdvance = 1'b1;
    case (clockControlReg_r[`DCT_CK_SCALE])
      `DCT_SC_DIV12: prescTerm = `DCT_PS_TERM12;
      `DCT_SC_DIV4:  prescTerm = `DCT_PS_TERM4;
      `DCT_SC_DIV48: prescTerm = `DCT_PS_TERM48;
      `DCT_SC_EXT8: begin
        prescTerm    = `DCT_PS_TERM8;
        prescAdvance = extClkRise;
      end
      default: prescTerm = `DCT_PS_TERM12;
    endcase
  end

  // Compare with >= so a switch to a shorter divide never runs past its end
  assign prescTick = prescAdvance & (presc_r >= prescTerm);

  always @(posedge ref_clk or negedge arst_n) begin
    if (!arst_n) begin
      presc_r <= `DCT_RST_PS;
    end else if (prescTick) begin
      presc_r <= `DCT_RST_PS;
    end else if (prescAdvance) begin
      presc_r <= presc_r + {{(`DCT_PS_W-1){1'b0}}, 1'b1};
    end
  end

  // ***************************************************************
  // Count enables and clock sources
  // ***************************************************************
  wire [1:0] firstMode  = timerModeReg_r[`DCT_MD_FIRST_MODE];
  wire [1:0] secondMode = timerModeReg_r[`DCT_MD_SECOND_MODE];
  wire       splitMode  = (firstMode == `DCT_MODE_SPLIT);

  wire firstGateActive  = extIrqConfigReg_r[`DCT_EC_FIRST_POL] ? firstGateLvl : ~firstGateLvl;
  wire secondGateActive = extIrqConfigReg_r[`DCT_EC_SECOND_POL] ? secondGateLvl
                                                                 : ~secondGateLvl;

  // Run bit only gates counting; it never touches the count itself
  wire firstEnable  = firstRunBit_r &
                      (~timerModeReg_r[`DCT_MD_FIRST_GATE] | firstGateActive);
  wire secondEnable = secondRunBit_r &
                      (~timerModeReg_r[`DCT_MD_SECOND_GATE] | secondGateActive);

  wire firstIntClk  = clockControlReg_r[`DCT_CK_FIRST_SYS] ? 1'b1 : prescTick;
  wire secondIntClk = clockControlReg_r[`DCT_CK_SECOND_SYS] ? 1'b1 : prescTick;

  wire firstTick  = timerModeReg_r[`DCT_MD_FIRST_CSEL] ? firstCntFall : firstIntClk;
  wire secondTick = timerModeReg_r[`DCT_MD_SECOND_CSEL] ? secondCntFall : secondIntClk;

  wire firstInc     = firstEnable & firstTick;
  wire splitHighInc = secondRunBit_r & firstIntClk;
  // In split mode the second timer runs from its mode alone and only on internal clocks
  wire secondInc    = splitMode ? ((secondMode != `DCT_MODE_SPLIT) & secondIntClk)
                                : (secondEnable & secondTick);

  // ***************************************************************
  // Counter step shared by both timers
  // ***************************************************************
  function [16:0] dctStep;
    input [1:0] md;
    input [7:0] hi;
    input [7:0] lo;
    input       inc;
    reg   [12:0] c13;
    reg   [15:0] c16;
    reg   [7:0]  c8;
    begin
      c13 = {hi, lo[4:0]} + 13'h0001;
      c16 = {hi, lo} + 16'h0001;
      c8  = lo + 8'h01;
      dctStep = {1'b0, hi, lo};
      if (inc) begin
        case (md)
          `DCT_MODE_13BIT: dctStep = {&{hi, lo[4:0]}, c13[12:5], lo[7:5], c13[4:0]};
          `DCT_MODE_16BIT: dctStep = {&{hi, lo}, c16};
          `DCT_MODE_RELOAD: dctStep = (&lo) ? {1'b1, hi, hi} : {1'b0, hi, c8};
          default: dctStep = {1'b0, hi, lo};
        endcase
      end
    end
  endfunction

  reg [7:0] firstLowNxt;
  reg [7:0] firstHighNxt;
  reg       firstOvf;
  reg       splitHighOvf;
  reg [7:0] secondLowNxt;
  reg [7:0] secondHighNxt;
  reg       secondOvf;

  always @* begin
    splitHighOvf = 1'b0;
    {firstOvf, firstHighNxt, firstLowNxt} = dctStep(firstMode, firstCountHigh_r,
                                                    firstCountLow_r, firstInc);
    if (splitMode) begin
      firstOvf     = firstInc & (&firstCountLow_r);
      firstLowNxt  = firstInc ? firstCountLow_r + 8'h01 : firstCountLow_r;
      splitHighOvf = splitHighInc & (&firstCountHigh_r);
      firstHighNxt = splitHighInc ? firstCountHigh_r + 8'h01 : firstCountHigh_r;
    end
    // Second timer in mode 3 falls to the hold branch of the step
    {secondOvf, secondHighNxt, secondLowNxt} = dctStep(secondMode, secondCountHigh_r,
                                                       secondCountLow_r, secondInc);
  end

  wire firstFlagSet  = firstOvf;
  wire secondFlagSet = splitMode ? splitHighOvf : secondOvf;

  // ***************************************************************
  // Register writes, counting and flags
  // ***************************************************************
  wire wrControl = regWrStb & (regAddr == `DCT_A_CONTROL);

  always @(posedge ref_clk or negedge arst_n) begin
    if (!arst_n) begin
      firstCountLow_r      <= `DCT_RST_BYTE;
      firstCountHigh_r     <= `DCT_RST_BYTE;
      secondCountLow_r     <= `DCT_RST_BYTE;
      secondCountHigh_r    <= `DCT_RST_BYTE;
      timerModeReg_r       <= `DCT_RST_BYTE;
      clockControlReg_r    <= `DCT_RST_BYTE;
      irqEnableReg_r       <= `DCT_RST_BYTE;
      extIrqConfigReg_r    <= `DCT_RST_BYTE;
      firstRunBit_r        <= 1'b0;
      secondRunBit_r       <= 1'b0;
      firstOverflowFlag_r  <= 1'b0;
      secondOverflowFlag_r <= 1'b0;
      ovfTick_r            <= 1'b0;
    end else begin
      // A software byte write beats the count step for that byte only
      firstCountLow_r   <= (regWrStb && regAddr == `DCT_A_FIRST_LOW) ? regWrData
                                                                     : firstLowNxt;
      firstCountHigh_r  <= (regWrStb && regAddr == `DCT_A_FIRST_HIGH) ? regWrData
                                                                      : firstHighNxt;
      secondCountLow_r  <= (regWrStb && regAddr == `DCT_A_SECOND_LOW) ? regWrData
                                                                      : secondLowNxt;
      secondCountHigh_r <= (regWrStb && regAddr == `DCT_A_SECOND_HIGH) ? regWrData
                                                                       : secondHighNxt;
      if (regWrStb && regAddr == `DCT_A_MODE) begin
        timerModeReg_r <= regWrData;
      end
      if (regWrStb && regAddr == `DCT_A_CLOCK_CTL) begin
        clockControlReg_r <= regWrData;
      end
      if (regWrStb && regAddr == `DCT_A_IRQ_ENABLE) begin
        irqEnableReg_r <= regWrData;
      end
      if (regWrStb && regAddr == `DCT_A_EXT_CONFIG) begin
        extIrqConfigReg_r <= regWrData;
      end
      if (wrControl) begin
        firstRunBit_r  <= regWrData[`DCT_CT_FIRST_RUN];
        secondRunBit_r <= regWrData[`DCT_CT_SECOND_RUN];
      end
      // Hardware set wins over a software clear or an acknowledge in the same cycle
      if (firstFlagSet) begin
        firstOverflowFlag_r <= 1'b1;
      end else if (wrControl) begin
        firstOverflowFlag_r <= regWrData[`DCT_CT_FIRST_OVF];
      end else if (firstIrqAck) begin
        firstOverflowFlag_r <= 1'b0;
      end
      if (secondFlagSet) begin
        secondOverflowFlag_r <= 1'b1;
      end else if (wrControl) begin
        secondOverflowFlag_r <= regWrData[`DCT_CT_SECOND_OVF];
      end else if (secondIrqAck) begin
        secondOverflowFlag_r <= 1'b0;
      end
      ovfTick_r <= secondOvf;
    end
  end

  // ***************************************************************
  // Register reads
  // ***************************************************************
  reg [7:0] rdMux;

  always @* begin
    rdMux = `DCT_RST_BYTE;
    case (regAddr)
      `DCT_A_CONTROL: begin
        rdMux[`DCT_CT_SECOND_OVF] = secondOverflowFlag_r;
        rdMux[`DCT_CT_SECOND_RUN] = secondRunBit_r;
        rdMux[`DCT_CT_FIRST_OVF]  = firstOverflowFlag_r;
        rdMux[`DCT_CT_FIRST_RUN]  = firstRunBit_r;
      end
      `DCT_A_MODE:        rdMux = timerModeReg_r;
      `DCT_A_FIRST_LOW:   rdMux = firstCountLow_r;
      `DCT_A_SECOND_LOW:  rdMux = secondCountLow_r;
      `DCT_A_FIRST_HIGH:  rdMux = firstCountHigh_r;
      `DCT_A_SECOND_HIGH: rdMux = secondCountHigh_r;
      `DCT_A_CLOCK_CTL:   rdMux = clockControlReg_r;
      `DCT_A_IRQ_ENABLE:  rdMux = irqEnableReg_r;
      `DCT_A_EXT_CONFIG:  rdMux = extIrqConfigReg_r;
      default:            rdMux = `DCT_RST_BYTE;
    endcase
  end

  // Read data stands only in the cycle after the strobe
  always @(posedge ref_clk or negedge arst_n) begin
    if (!arst_n) begin
      rdData_r <= `DCT_RST_BYTE;
    end else if (regRdStb) begin
      rdData_r <= rdMux;
    end else begin
      rdData_r <= `DCT_RST_BYTE;
    end
  end

  // ***************************************************************
  // Outputs
  // ***************************************************************
  assign regRdData          = rdData_r;
  assign firstIrqReq        = firstOverflowFlag_r & irqEnableReg_r[`DCT_IE_FIRST];
  assign secondIrqReq       = secondOverflowFlag_r & irqEnableReg_r[`DCT_IE_SECOND];
  assign secondOverflowTick = ovfTick_r;

endmodule // dct_timer_top

`default_nettype wire

// file: tb/dct_timer_checker.sv
// Port-level assertions for the dual counter/timer
`timescale 1ns/10ps
`default_nettype none
`include "dct_map.vh"

module dct_timer_checker (
  // Clock and reset
  input wire logic                   ref_clk,
  input wire logic                   arst_n,
  // Register port
  input wire logic [`DCT_ADDR_W-1:0] regAddr,
  input wire logic [7:0]             regWrData,
  input wire logic                   regWrStb,
  input wire logic                   regRdStb,
  input wire logic [7:0]             regRdData,
  // Requests
  input wire logic                   firstIrqReq,
  input wire logic                   secondIrqReq
);
  default clocking cb @(posedge ref_clk);
  endclocking
  default disable iff (!arst_n);

  // ***************************************************************
  // Register access steps
  // ***************************************************************
  sequence s_wr(a);
    regWrStb && regAddr == a;
  endsequence
  sequence s_rd(a);
    regRdStb && regAddr == a;
  endsequence

  a_rd_idle_zero: assert property (!$past(regRdStb) |-> regRdData == 8'h00)
    else $error("read data not zero outside read cycle");
  a_unmapped_zero: assert property (regRdStb && regAddr > `DCT_A_EXT_CONFIG
    |=> regRdData == 8'h00)
    else $error("unmapped read not zero");
  a_ctrl_low_zero: assert property (s_rd(`DCT_A_CONTROL) |=> regRdData[3:0] == 4'h0)
    else $error("control low bits not zero");
  a_first_irq_mask: assert property (s_wr(`DCT_A_IRQ_ENABLE)
    ##0 !regWrData[`DCT_IE_FIRST] |=> !firstIrqReq)
    else $error("first request while disabled");
  a_second_irq_mask: assert property (s_wr(`DCT_A_IRQ_ENABLE)
    ##0 !regWrData[`DCT_IE_SECOND] |=> !secondIrqReq)
    else $error("second request while disabled");
  a_mode_readback: assert property (s_wr(`DCT_A_MODE) ##1 s_rd(`DCT_A_MODE)
    |=> regRdData == $past(regWrData, 2))
    else $error("mode register readback wrong");
  a_clk_readback: assert property (s_wr(`DCT_A_CLOCK_CTL) ##1 s_rd(`DCT_A_CLOCK_CTL)
    |=> (regRdData & 8'h0F) == ($past(regWrData, 2) & 8'h0F))
    else $error("clock control readback wrong");
  a_cfg_readback: assert property (s_wr(`DCT_A_EXT_CONFIG) ##1 s_rd(`DCT_A_EXT_CONFIG)
    |=> (regRdData & 8'h03) == ($past(regWrData, 2) & 8'h03))
    else $error("polarity readback wrong");
endmodule // dct_timer_checker

bind dct_timer_top dct_timer_checker dct_timer_checker_i (
  .ref_clk(ref_clk), .arst_n(arst_n), .regAddr(regAddr), .regWrData(regWrData),
  .regWrStb(regWrStb), .regRdStb(regRdStb), .regRdData(regRdData),
  .firstIrqReq(firstIrqReq), .secondIrqReq(secondIrqReq)
);
`default_nettype wire

// file: tb/dct_pin_partner.sv
// Model of the pins around the timer: count pins, gate inputs, prescaler clock
`timescale 1ns/10ps
`default_nettype none

module dct_pin_partner (
  // Bench control
  input  wire logic extRun,
  // Pins
  output var  logic firstCountPin,
  output var  logic secondCountPin,
  output var  logic firstExtIrqInput,
  output var  logic secondExtIrqInput,
  output var  logic extClockPin
);
  initial begin
    // Count pins rest high behind a pull-up
    firstCountPin = 1'h1;
    secondCountPin = 1'h1;
    firstExtIrqInput = 1'h0;
    secondExtIrqInput = 1'h0;
    extClockPin = 1'h0;
  end

  // Stands still unless asked, so no stray prescaler edges
  always begin
    #200;
    if (extRun) extClockPin = ~extClockPin;
  end

  // Falling edges six clock periods apart, slower than the synchroniser
  task automatic pulse(input logic sel, input int n);
    repeat (n) begin
      if (sel) secondCountPin = 1'h0; else firstCountPin = 1'h0;
      #300;
      secondCountPin = 1'h1;
      firstCountPin = 1'h1;
      #300;
    end
  endtask

  task automatic setGate(input logic sel, input logic lvl);
    if (sel) secondExtIrqInput = lvl; else firstExtIrqInput = lvl;
  endtask
endmodule // dct_pin_partner
`default_nettype wire

// file: tb/dct_timer_top_tb.sv
// Self-checking testbench for the dual counter/timer
`timescale 1ns/10ps
`default_nettype none
`include "dct_map.vh"

module dct_timer_top_tb;
  logic                   ref_clk, arst_n, regWrStb, regRdStb, firstIrqAck, secondIrqAck, extRun;
  logic [`DCT_ADDR_W-1:0] regAddr;
  logic [7:0]             regWrData, d, e;
  wire  [7:0]             regRdData;
  wire                    firstCountPin, secondCountPin, firstExtIrqInput, secondExtIrqInput;
  wire                    extClockPin, firstIrqReq, secondIrqReq, secondOverflowTick;
  int                     n_fail, n_compared, i;

  dct_timer_top dct_timer_top_i (.ref_clk(ref_clk), .arst_n(arst_n), .regAddr(regAddr),
    .regWrData(regWrData), .regWrStb(regWrStb), .regRdStb(regRdStb), .regRdData(regRdData),
    .firstCountPin(firstCountPin), .secondCountPin(secondCountPin),
    .firstExtIrqInput(firstExtIrqInput), .secondExtIrqInput(secondExtIrqInput),
    .extClockPin(extClockPin), .firstIrqAck(firstIrqAck), .secondIrqAck(secondIrqAck),
    .firstIrqReq(firstIrqReq), .secondIrqReq(secondIrqReq),
    .secondOverflowTick(secondOverflowTick));
  dct_pin_partner dct_pin_partner_i (.extRun(extRun), .firstCountPin(firstCountPin),
    .secondCountPin(secondCountPin), .firstExtIrqInput(firstExtIrqInput),
    .secondExtIrqInput(secondExtIrqInput), .extClockPin(extClockPin));

  // ***************************************************************
  // Bus, wait and compare helpers
  // ***************************************************************
  task automatic wr(input logic [`DCT_ADDR_W-1:0] a, input logic [7:0] v);
    regAddr <= a; regWrData <= v; regWrStb <= 1'h1;
    @(posedge ref_clk);
    regWrStb <= 1'h0;
    #1;
  endtask
  task automatic rd(input logic [`DCT_ADDR_W-1:0] a, output logic [7:0] v);
    regAddr <= a; regRdStb <= 1'h1;
    @(posedge ref_clk);
    regRdStb <= 1'h0;
    #1;
    v = regRdData;
  endtask
  task automatic ack(input logic s);
    if (s) secondIrqAck <= 1'h1; else firstIrqAck <= 1'h1;
    @(posedge ref_clk);
    firstIrqAck <= 1'h0; secondIrqAck <= 1'h0;
    #1;
  endtask
  task automatic chk8(input string nm, input logic [7:0] x, input logic [7:0] g);
    n_compared++;
    if (g !== x) begin n_fail++; $display("Error %s expected %h seen %h", nm, x, g); end
  endtask
  task automatic chk1(input string nm, input logic x, input logic g);
    n_compared++;
    if (g !== x) begin n_fail++; $display("Error %s expected %b seen %b", nm, x, g); end
  endtask
  // Polls after each edge; the tick is a one-cycle pulse so every cycle is looked at
  task automatic waitFor(input int w);
    for (int k = 0; k < 400; k++) begin
      @(posedge ref_clk);
      #1;
      if ((w == 0 && firstIrqReq === 1'h1) || (w == 1 && secondIrqReq === 1'h1)
          || (w == 2 && secondOverflowTick === 1'h1)) return;
    end
    n_fail++;
    $display("Error wait %0d expected 1 seen 0", w);
    tally_and_finish();
  endtask
  task automatic tally_and_finish;
    $display("Compared %0d mismatches %0d", n_compared, n_fail);
    if (n_fail == 0 && n_compared > 0) $display("All checks passed");
    else $display("Checks failed");
    $finish;
  endtask
  // Common start: load the first timer, set mode, clock, enables and control
  task automatic setup(input logic [7:0] md, ck, lo, hi, ie, ct);
    wr(`DCT_A_MODE, md); wr(`DCT_A_CLOCK_CTL, ck); wr(`DCT_A_FIRST_LOW, lo);
    wr(`DCT_A_FIRST_HIGH, hi); wr(`DCT_A_IRQ_ENABLE, ie); wr(`DCT_A_CONTROL, ct);
  endtask

  // ***************************************************************
  // Scenarios
  // ***************************************************************
  task automatic s_regs;
    rd(`DCT_A_CONTROL, d); chk8("control", 8'h00, d);
    rd(`DCT_A_SECOND_HIGH, d); chk8("second high", 8'h00, d);
    rd(4'hF, d); chk8("unmapped", 8'h00, d);
    wr(`DCT_A_MODE, 8'hA5); rd(`DCT_A_MODE, d); chk8("mode", 8'hA5, d);
    wr(`DCT_A_CLOCK_CTL, 8'h0D); rd(`DCT_A_CLOCK_CTL, d);
    chk8("clkctl", 8'h0D, d & 8'h0F);
    wr(`DCT_A_EXT_CONFIG, 8'h03); rd(`DCT_A_EXT_CONFIG, d);
    chk8("polarity", 8'h03, d & 8'h03);
  endtask
  task automatic s_mode1;
    setup(8'h01, 8'h04, 8'hFE, 8'hFF, 8'h01, 8'h10);
    waitFor(0);
    wr(`DCT_A_CONTROL, 8'h20);
    rd(`DCT_A_FIRST_HIGH, d); chk8("m1 high", 8'h00, d);
    rd(`DCT_A_FIRST_LOW, d); chk8("m1 low", 8'h01, d);
    rd(`DCT_A_FIRST_LOW, e); chk8("m1 held", d, e);
    chk1("m1 req", 1'h1, firstIrqReq);
    ack(1'h0); chk1("m1 ack", 1'h0, firstIrqReq);
  endtask
  task automatic s_mode0;
    setup(8'h00, 8'h04, 8'h1E, 8'hFF, 8'h00, 8'h10);
    repeat (3) @(posedge ref_clk);
    rd(`DCT_A_CONTROL, d); chk1("m0 flag", 1'h1, d[`DCT_CT_FIRST_OVF]);
    chk1("m0 req off", 1'h0, firstIrqReq);
    wr(`DCT_A_CONTROL, 8'h00);
    rd(`DCT_A_FIRST_HIGH, d); chk8("m0 high", 8'h00, d);
    rd(`DCT_A_FIRST_LOW, d); chk8("m0 low", 8'h03, d & 8'h1F);
  endtask
  task automatic s_reload;
    setup(8'h02, 8'h04, 8'hFE, 8'hF0, 8'h01, 8'h10);
    waitFor(0);
    wr(`DCT_A_CONTROL, 8'h00);
    rd(`DCT_A_FIRST_HIGH, d); chk8("reload high", 8'hF0, d);
    rd(`DCT_A_FIRST_LOW, d); chk8("reload low", 8'hF1, d);
  endtask
  task automatic s_gate;
    wr(`DCT_A_SECOND_LOW, 8'h00); wr(`DCT_A_EXT_CONFIG, 8'h02);
    setup(8'h90, 8'h08, 8'h00, 8'h00, 8'h00, 8'h40);
    repeat (10) @(posedge ref_clk);
    rd(`DCT_A_SECOND_LOW, d); chk8("gate closed", 8'h00, d);
    dct_pin_partner_i.setGate(1'h1, 1'h1);
    repeat (10) @(posedge ref_clk);
    wr(`DCT_A_CONTROL, 8'h00); dct_pin_partner_i.setGate(1'h1, 1'h0);
    rd(`DCT_A_SECOND_LOW, d); chk8("gate open", 8'h09, d);
  endtask
  task automatic s_pins;
    setup(8'h55, 8'h00, 8'h10, 8'h00, 8'h00, 8'h50);
    dct_pin_partner_i.pulse(1'h0, 5);
    dct_pin_partner_i.pulse(1'h1, 2);
    repeat (5) @(posedge ref_clk);
    #1;
    wr(`DCT_A_CONTROL, 8'h00);
    rd(`DCT_A_FIRST_LOW, d); chk8("pin count", 8'h15, d);
    rd(`DCT_A_SECOND_LOW, d); chk8("second pin", 8'h0B, d);
  endtask
  task automatic s_scale;
    int dv[4] = '{12, 4, 48, 32};
    for (i = 0; i < 4; i++) begin
      extRun <= (i == 3);
      setup(8'h01, i[7:0], 8'h00, 8'h00, 8'h00, 8'h10);
      repeat (dv[i] * 6) @(posedge ref_clk);
      wr(`DCT_A_CONTROL, 8'h00);
      rd(`DCT_A_FIRST_LOW, d); chk1("scaled", 1'h1, d >= 8'h05 && d <= 8'h07);
    end
    extRun <= 1'h0;
  endtask
  task automatic s_split;
    wr(`DCT_A_SECOND_LOW, 8'hF0); wr(`DCT_A_SECOND_HIGH, 8'hFF);
    setup(8'h13, 8'h0C, 8'hFE, 8'h00, 8'h03, 8'h50);
    waitFor(2);
    chk1("split low req", 1'h1, firstIrqReq);
    chk1("split no second", 1'h0, secondIrqReq);
    wr(`DCT_A_MODE, 8'h33);
    rd(`DCT_A_SECOND_LOW, d); rd(`DCT_A_SECOND_LOW, e); chk8("second stops", d, e);
    wr(`DCT_A_FIRST_HIGH, 8'hFC);
    waitFor(1);
    ack(1'h1); chk1("split ack", 1'h0, secondIrqReq);
  endtask

  initial begin
    ref_clk = 1'h0;
    forever #50 ref_clk = ~ref_clk;
  end

  initial begin
    n_fail = 0; n_compared = 0; arst_n = 1'h0; regWrStb = 1'h0; regRdStb = 1'h0;
    regAddr = 4'h0; regWrData = 8'h00; firstIrqAck = 1'h0; secondIrqAck = 1'h0; extRun = 1'h0;
    repeat (3) @(posedge ref_clk);
    arst_n <= 1'h1;
    @(posedge ref_clk);
    #1;
    s_regs(); s_mode1(); s_mode0(); s_reload(); s_gate(); s_pins(); s_scale(); s_split();
    tally_and_finish();
  end
endmodule // dct_timer_top_tb
`default_nettype wire
